// ===== hdl/ebpt_timer.sv
/*
 * ebpt_timer: eight-bit period timer with prescaler, period match,
 * postscaler and a level interrupt, reached over a plain register port.
 * assumes: one 20 MHz master clock, async active-low reset, a bus master
 * that never drives both strobes in one cycle.
 */
// Summary of operation
// - count clock is master clock divided four
// - prescale 1, 4, or 16 by select field
// - count from zero, reload zero after match
// - each period match advances the postscaler
// - postscale ratio is select value plus one
// - postscaler completion sets match flag
// - reset: count 00h, period FFh
// - count and period fully readable and writable
// - run enable bit starts and stops counting
// - count or control write clears both scalers
// - control write leaves count untouched
// - control layout: bit7 zero, post, run, pre
// - interrupt needs flag, enable, peripheral, global
`timescale 1ns/10ps
module ebpt_timer
(
    input  wire logic                        mclk,
    input  wire logic                        resetn,
    input  wire ebpt_pkg::ebpt_req_t         req,
    output logic      [ebpt_pkg::DATA_W-1:0] rdata,
    output logic                             irq,
    output logic                             post_tick
);
    import ebpt_pkg::*;

    ebpt_state_t state;
    ebpt_state_t next_state;

    function automatic logic [3:0] pre_last(input logic [1:0] sel);
        if (sel == PRE_SEL_1)
            return PRE_LAST_1;
        else if (sel == PRE_SEL_4)
            return PRE_LAST_4;
        else
            return PRE_LAST_16;
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] b,
                                 input logic              s);
        return s && (a == b);
    endfunction

    logic inst_tick;
    logic pre_tick;
    logic match;
    logic wr_count;
    logic wr_ctl;
    logic wr_period;
    logic flag_set;

    always_comb
    begin
        next_state = state;
        wr_count   = hit(req.addr, ADDR_TIMER_COUNT, req.wr);
        wr_ctl     = hit(req.addr, ADDR_TIMER_CONTROL, req.wr);
        wr_period  = hit(req.addr, ADDR_PERIOD_COMPARE, req.wr);
        // free-running quarter-rate divider forms the instruction clock
        inst_tick  = (state.qdiv == QDIV_LAST);
        next_state.qdiv = state.qdiv + 2'h1;
        match      = (state.count_register == state.period_register);
        pre_tick   = 1'b0;
        flag_set   = 1'b0;
        next_state.post_tick = 1'b0;

        if (state.ctl.run_enable && inst_tick)
        begin
            if (state.pre_cnt >= pre_last(state.ctl.prescale_select))
            begin
                pre_tick = 1'b1;
                next_state.pre_cnt = RST_PRE_CNT;
            end
            else
                next_state.pre_cnt = state.pre_cnt + ONE4;
        end

        if (pre_tick)
        begin
            if (match)
            begin
                next_state.count_register = ZERO8;
                // ratio is select plus one, so terminal count is the select
                if (state.pst_cnt >= state.ctl.postscale_select)
                begin
                    next_state.pst_cnt   = RST_PST_CNT;
                    flag_set             = 1'b1;
                    next_state.post_tick = 1'b1;
                end
                else
                    next_state.pst_cnt = state.pst_cnt + ONE4;
            end
            else
                next_state.count_register = state.count_register + ONE8;
        end

        // software write to count wins over the increment
        if (wr_count)
        begin
            next_state.count_register = req.wdata;
            next_state.pre_cnt        = RST_PRE_CNT;
            next_state.pst_cnt        = RST_PST_CNT;
        end
        if (wr_period)
            next_state.period_register = req.wdata;
        if (wr_ctl)
        begin
            // count is deliberately not touched here
            next_state.ctl.prescale_select  = req.wdata[CTL_PRE_MSB:CTL_PRE_LSB];
            next_state.ctl.run_enable       = req.wdata[CTL_RUN_BIT];
            next_state.ctl.postscale_select = req.wdata[CTL_POST_MSB:CTL_POST_LSB];
            next_state.pre_cnt = RST_PRE_CNT;
            next_state.pst_cnt = RST_PST_CNT;
        end

        // status: software writes 1 or 0; a clear write also clears it
        if (hit(req.addr, ADDR_IRQ_STATUS, req.wr))
            next_state.match_flag = req.wdata[IRQ_MATCH_BIT];
        if (hit(req.addr, ADDR_IRQ_CLEAR, req.wr) && req.wdata[IRQ_MATCH_BIT])
            next_state.match_flag = 1'b0;
        // hardware set wins over a same-cycle software clear
        if (flag_set)
            next_state.match_flag = 1'b1;
        if (hit(req.addr, ADDR_IRQ_ENABLE, req.wr))
            next_state.match_irq_enable = req.wdata[IRQ_MATCH_BIT];
        if (hit(req.addr, ADDR_IRQ_GLOBAL, req.wr))
        begin
            next_state.global_irq_enable     = req.wdata[GLB_GLOBAL_BIT];
            next_state.peripheral_irq_enable = req.wdata[GLB_PERIPH_BIT];
        end

        next_state.irq = next_state.match_flag && next_state.match_irq_enable
                         && next_state.peripheral_irq_enable
                         && next_state.global_irq_enable;

        next_state.rdata = ZERO8;
        if (req.rd)
        begin
            case (req.addr)
                ADDR_TIMER_COUNT:
                    next_state.rdata = state.count_register;
                ADDR_PERIOD_COMPARE:
                    next_state.rdata = state.period_register;
                ADDR_TIMER_CONTROL:
                    next_state.rdata = {1'b0, state.ctl};
                ADDR_IRQ_STATUS:
                    next_state.rdata = {7'h00, state.match_flag};
                ADDR_IRQ_ENABLE:
                    next_state.rdata = {7'h00, state.match_irq_enable};
                ADDR_IRQ_GLOBAL:
                    next_state.rdata = {6'h00, state.peripheral_irq_enable,
                                        state.global_irq_enable};
                default:
                    next_state.rdata = ZERO8;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            state                       <= '0;
            state.count_register        <= RST_COUNT;
            state.period_register       <= RST_PERIOD;
            state.ctl.postscale_select  <= RST_POST;
            state.ctl.prescale_select   <= RST_PRE;
            state.qdiv                  <= RST_QDIV;
            state.pre_cnt               <= RST_PRE_CNT;
            state.pst_cnt               <= RST_PST_CNT;
        end
        else
            state <= next_state;
    end

    assign rdata     = state.rdata;
    assign irq       = state.irq;
    assign post_tick = state.post_tick;

endmodule

// ===== hdl/ebpt_pkg.sv
/*
 * ebpt_pkg: register map, field layout, reset values and carriers for the
 * eight-bit period timer.
 * assumes: a plain strobed register port with 8-bit data on one clock.
 */
package ebpt_pkg;

    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;

    // register indices on the plain port
    localparam logic [2:0] ADDR_TIMER_COUNT    = 3'h0;
    localparam logic [2:0] ADDR_PERIOD_COMPARE = 3'h1;
    localparam logic [2:0] ADDR_TIMER_CONTROL  = 3'h2;
    localparam logic [2:0] ADDR_IRQ_STATUS     = 3'h3;
    localparam logic [2:0] ADDR_IRQ_CLEAR      = 3'h4;
    localparam logic [2:0] ADDR_IRQ_ENABLE     = 3'h5;
    localparam logic [2:0] ADDR_IRQ_GLOBAL     = 3'h6;

    // control register fields
    localparam int unsigned CTL_PRE_LSB  = 0;
    localparam int unsigned CTL_PRE_MSB  = 1;
    localparam int unsigned CTL_RUN_BIT  = 2;
    localparam int unsigned CTL_POST_LSB = 3;
    localparam int unsigned CTL_POST_MSB = 6;

    // interrupt registers: bit 0 is the match flag
    localparam int unsigned IRQ_MATCH_BIT  = 0;
    // global register: bit 0 global enable, bit 1 peripheral enable
    localparam int unsigned GLB_GLOBAL_BIT = 0;
    localparam int unsigned GLB_PERIPH_BIT = 1;

    // reset values
    localparam logic [7:0] RST_COUNT   = 8'h00;
    localparam logic [7:0] RST_PERIOD  = 8'hFF;
    localparam logic [3:0] RST_POST    = 4'h0;
    localparam logic [1:0] RST_PRE     = 2'h0;
    localparam logic [3:0] RST_PRE_CNT = 4'h0;
    localparam logic [3:0] RST_PST_CNT = 4'h0;
    localparam logic [1:0] RST_QDIV    = 2'h0;

    // instruction clock ticks when the master-clock divider reaches this last value, so divide by four
    localparam logic [1:0] QDIV_LAST   = 2'h3;

    // prescale select codes and terminal counts
    localparam logic [1:0] PRE_SEL_1   = 2'h0;
    localparam logic [1:0] PRE_SEL_4   = 2'h1;
    localparam logic [3:0] PRE_LAST_1  = 4'h0;
    localparam logic [3:0] PRE_LAST_4  = 4'h3;
    localparam logic [3:0] PRE_LAST_16 = 4'hF;

    localparam logic [7:0] ONE8  = 8'h01;
    localparam logic [3:0] ONE4  = 4'h1;
    localparam logic [7:0] ZERO8 = 8'h00;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ebpt_req_t;

    typedef struct packed {
        logic [3:0] postscale_select;
        logic       run_enable;
        logic [1:0] prescale_select;
    } ebpt_ctl_t;

    typedef struct packed {
        logic [7:0] count_register;
        logic [7:0] period_register;
        ebpt_ctl_t  ctl;
        logic [1:0] qdiv;
        logic [3:0] pre_cnt;
        logic [3:0] pst_cnt;
        logic       match_flag;
        logic       match_irq_enable;
        logic       global_irq_enable;
        logic       peripheral_irq_enable;
        logic [7:0] rdata;
        logic       irq;
        logic       post_tick;
    } ebpt_state_t;

endpackage

// ===== tb/ebpt_sva.sv
/*
 * ebpt_sva: port assertions and covers for the eight-bit period timer.
 * assumes: bound to ebpt_timer, one clock domain, async active-low reset.
 */
`timescale 1ns/10ps
module ebpt_sva
    import ebpt_pkg::*;
(
    input wire logic                 mclk,
    input wire logic                 resetn,
    input wire ebpt_pkg::ebpt_req_t  req,
    input wire logic [DATA_W-1:0]    rdata,
    input wire logic                 irq,
    input wire logic                 post_tick
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    AST_RD_IDLE: assert property (!req.rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    // instruction tick is every fourth clock, so pulses can never be closer
    AST_TICK_GAP: assert property (post_tick |=> !post_tick [*3])
        else $error("match pulses closer than four clocks");
    AST_PERIOD_RW: assert property ((req.wr && req.addr == ADDR_PERIOD_COMPARE) ##1
        (req.rd && req.addr == ADDR_PERIOD_COMPARE) |=> rdata == $past(req.wdata, 2))
        else $error("period readback differs from write");
    AST_CTL_B7: assert property (req.rd && req.addr == ADDR_TIMER_CONTROL |=> !rdata[7])
        else $error("control bit 7 reads one");
    AST_CLR_RD0: assert property (req.rd && req.addr == ADDR_IRQ_CLEAR |=> rdata == 8'h00)
        else $error("clear register not read as zero");
    AST_FLAG_STICKY: assert property ((post_tick && !req.wr) ##1
        (req.rd && req.addr == ADDR_IRQ_STATUS) |=> rdata[IRQ_MATCH_BIT])
        else $error("match flag not set after postscaler pulse");
    AST_FLAG_CLR: assert property ((req.wr && req.addr == ADDR_IRQ_STATUS &&
        !req.wdata[IRQ_MATCH_BIT]) ##1 (req.rd && req.addr == ADDR_IRQ_STATUS && !post_tick)
        |=> !rdata[IRQ_MATCH_BIT])
        else $error("match flag survived a software clear");
    AST_IRQ_OFF: assert property ((req.wr && req.addr == ADDR_IRQ_GLOBAL &&
        !req.wdata[GLB_GLOBAL_BIT]) ##1 !req.wr |=> !irq)
        else $error("irq high with global enable clear");

    cover property (post_tick);
    cover property (irq);
    cover property (req.rd && req.addr == ADDR_IRQ_STATUS ##1 rdata[IRQ_MATCH_BIT]);
endmodule

bind ebpt_timer ebpt_sva sva_u (.mclk(mclk), .resetn(resetn), .req(req), .rdata(rdata),
    .irq(irq), .post_tick(post_tick));

// ===== tb/testbench.sv
/*
 * testbench: register-level tests of the eight-bit period timer.
 * assumes: ebpt_timer and its package from hdl/, checker bound on its own.
 */
`timescale 1ns/10ps
module testbench;
    import ebpt_pkg::*;
    logic       mclk;
    logic       resetn;
    ebpt_req_t  req;
    logic [7:0] rdata;
    logic       irq;
    logic       post_tick;
    int         errors;
    int         checks_done;
    int         gap;

    ebpt_timer dut_u (.mclk(mclk), .resetn(resetn), .req(req), .rdata(rdata), .irq(irq),
        .post_tick(post_tick));

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // write strobe is left up so a read can follow back to back; idle drops it
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{a, d, 1'b1, 1'b0};
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk) req <= '0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk);
        req <= '0;
        #1 chk(what, exp, rdata);
    endtask

    task automatic wait_tick();
        gap = 0;
        do
        begin
            @(negedge mclk);
            gap++;
        end
        while (post_tick !== 1'b1 && gap < 300);
    endtask

    // first interval may start from a stale pulse, so the third is measured
    task automatic gap_chk(input logic [7:0] per, input logic [7:0] ctl, input logic [7:0] exp);
        // count may sit above the new period and would wrap through FFh first
        wr(ADDR_TIMER_COUNT, 8'h00);
        wr(ADDR_PERIOD_COMPARE, per);
        wr(ADDR_TIMER_CONTROL, ctl);
        idle(1);
        repeat (3) wait_tick();
        chk("tick gap", exp, gap[7:0]);
        rd(ADDR_IRQ_STATUS, 8'h01, "status");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #(50 * 20000);
        errors++;
        give_verdict();
    end

    initial
    begin
        errors = 0;
        checks_done = 0;
        gap = 0;
        resetn = 1'b0;
        req = '0;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        rd(ADDR_TIMER_COUNT, 8'h00, "count");
        rd(ADDR_PERIOD_COMPARE, 8'hFF, "period");
        rd(ADDR_TIMER_CONTROL, 8'h00, "control");
        rd(3'h7, 8'h00, "unmapped");
        rd(ADDR_IRQ_CLEAR, 8'h00, "clear");
        wr(ADDR_PERIOD_COMPARE, 8'hA5);
        rd(ADDR_PERIOD_COMPARE, 8'hA5, "period");
        wr(ADDR_TIMER_COUNT, 8'h3C);
        rd(ADDR_TIMER_COUNT, 8'h3C, "count");
        wr(ADDR_TIMER_CONTROL, 8'hFF);
        rd(ADDR_TIMER_CONTROL, 8'h7F, "control");
        rd(ADDR_TIMER_COUNT, 8'h3C, "count");
        wr(ADDR_TIMER_CONTROL, 8'h00);
        idle(100);
        rd(ADDR_TIMER_COUNT, 8'h3C, "count");
        $display("test registers done");
        gap_chk(8'h00, 8'h04, 8'd4);
        gap_chk(8'h00, 8'h05, 8'd16);
        gap_chk(8'h00, 8'h06, 8'd64);
        gap_chk(8'h00, 8'h07, 8'd64);
        gap_chk(8'h02, 8'h04, 8'd12);
        gap_chk(8'h01, 8'h14, 8'd24);
        gap_chk(8'h00, 8'h7C, 8'd64);
        $display("test timing done");
        wr(ADDR_TIMER_CONTROL, 8'h00);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        wr(ADDR_IRQ_GLOBAL, 8'h03);
        idle(3);
        #1 chk("irq", 8'h01, {7'h00, irq});
        wr(ADDR_IRQ_GLOBAL, 8'h02);
        idle(3);
        #1 chk("irq", 8'h00, {7'h00, irq});
        wr(ADDR_IRQ_GLOBAL, 8'h03);
        wr(ADDR_IRQ_CLEAR, 8'h01);
        idle(3);
        #1 chk("irq", 8'h00, {7'h00, irq});
        rd(ADDR_IRQ_STATUS, 8'h00, "status");
        wr(ADDR_IRQ_STATUS, 8'h01);
        rd(ADDR_IRQ_STATUS, 8'h01, "status");
        wr(ADDR_IRQ_STATUS, 8'h00);
        rd(ADDR_IRQ_STATUS, 8'h00, "status");
        $display("test interrupt done");
        give_verdict();
    end
endmodule
